/* File: hw/alc_gain_loop.sv */
// gain loop controller for the input amplifier, with apb registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module alc_gain_loop
    import alc_pkg::*;
#(
    parameter logic [31:0] ATK_LIM_CYC = ATK_LIM_BASE_CYC,
    parameter logic [31:0] DCY_LIM_CYC = DCY_LIM_BASE_CYC,
    parameter logic [31:0] ATK_NORM_CYC = ATK_NORM_BASE_CYC,
    parameter logic [31:0] DCY_NORM_CYC = DCY_NORM_BASE_CYC,
    parameter logic [31:0] HOLD_CYC = HOLD_BASE_CYC
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_above_threshold,
    input wire logic i_above_peak,
    input wire logic [7:0] i_adc_atten_db,
    input wire logic [5:0] i_boost_db,
    output logic [GAIN_W-1:0] o_pga_gain
);

    function automatic logic [31:0] scaled(input logic [31:0] base,
                                           input logic [3:0] code);
        logic [3:0] c;
        c = (code > RATE_CODE_MAX) ? RATE_CODE_MAX : code;
        return base << c;
    endfunction

    function automatic logic is_mapped(input logic [9:0] idx);
        return idx >= IDX_GAIN_LIMITS && idx <= IDX_LOOP_STATUS;
    endfunction

    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [5:0] limits_reg;
    logic [3:0] hold_code_reg;
    logic [7:0] rates_reg;
    logic [3:0] gate_reg;
    logic enable_reg;
    logic mode_reg;
    logic enable_prev_reg;
    logic mode_prev_reg;
    logic [GAIN_W-1:0] gain_reg;
    logic [GAIN_W-1:0] start_reg;
    logic [GAIN_W-1:0] start_w;
    logic start_cap_w;
    state_t state_reg;
    state_t state_next;
    logic [31:0] cnt_reg;
    logic [31:0] rd_w;
    logic [31:0] cur_int_w;
    logic [31:0] hold_len_w;
    logic [31:0] atk_base_w;
    logic [31:0] dcy_base_w;
    logic [9:0] idx_w;
    logic access_w;
    logic wr_fire_w;
    logic wr_vol_w;
    logic thr_s;
    logic peak_s;
    logic over_s;
    logic step_w;
    logic gate_w;
    logic [10:0] gate_lhs_w;
    logic [10:0] gate_rhs_w;
    logic [GAIN_W-1:0] ceil_w;
    logic [GAIN_W-1:0] upper_w;
    logic [GAIN_W-1:0] lower_w;
    state_t decay_or_hold_w;

    // level detector is analogue-side, so everything is resynchronised
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_above_threshold, i_above_peak,
                          i_adc_atten_db, i_boost_db};
            sync2_reg <= sync1_reg;
        end
    end

    assign thr_s = sync2_reg[15];
    assign peak_s = enable_reg && sync2_reg[14];
    assign over_s = thr_s || peak_s;

    // apb: one wait state so read data comes from a flop
    assign idx_w = i_paddr[11:2];
    assign access_w = i_psel && i_penable;
    assign wr_fire_w = access_w && pready_reg && i_pwrite
                       && i_paddr[1:0] == 2'h0;
    assign wr_vol_w = wr_fire_w && idx_w == IDX_AMP_VOLUME;

    always_comb begin
        rd_w = '0;
        case (idx_w)
            IDX_GAIN_LIMITS: rd_w[5:0] = limits_reg;
            IDX_HOLD_DELAY: rd_w[HOLD_LSB+:4] = hold_code_reg;
            IDX_RATES: rd_w[7:0] = rates_reg;
            IDX_QUIET_GATE: rd_w[3:0] = gate_reg;
            IDX_LOOP_CTRL: rd_w[1:0] = {mode_reg, enable_reg};
            IDX_AMP_VOLUME: rd_w[GAIN_W-1:0] = gain_reg;
            IDX_LOOP_STATUS: rd_w[3:0] = {gate_w, peak_s, state_reg};
            default: rd_w = '0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= access_w && !pready_reg;
            if (access_w && !pready_reg) begin
                pslverr_reg <= !is_mapped(idx_w) || i_paddr[1:0] != 2'h0;
                prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_w;
            end else begin
                pslverr_reg <= 1'b0;
                prdata_reg <= '0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            limits_reg <= LIMITS_RST;
            hold_code_reg <= HOLD_RST;
            rates_reg <= RATES_RST;
            gate_reg <= GATE_RST;
            enable_reg <= 1'b0;
            mode_reg <= 1'b0;
        end else if (wr_fire_w) begin
            case (idx_w)
                IDX_GAIN_LIMITS: limits_reg <= i_pwdata[5:0];
                IDX_HOLD_DELAY: hold_code_reg <= i_pwdata[HOLD_LSB+:4];
                IDX_RATES: rates_reg <= i_pwdata[7:0];
                IDX_QUIET_GATE: gate_reg <= i_pwdata[3:0];
                IDX_LOOP_CTRL: begin
                    enable_reg <= i_pwdata[0];
                    mode_reg <= i_pwdata[CTRL_MODE_BIT];
                end
                default: ;
            endcase
        end
    end

    // limits: codes map onto 0.75dB amplifier steps, -12dB at zero
    assign ceil_w = {limits_reg[CEIL_LSB+:3], 3'b111};
    assign lower_w = {limits_reg[2:0], 3'b000};
    assign start_cap_w = enable_reg
                         && (!enable_prev_reg || (mode_reg && !mode_prev_reg));
    assign start_w = start_cap_w ? gain_reg : start_reg;
    assign upper_w = (mode_reg && start_w < ceil_w) ? start_w
                                                    : ceil_w;

    // quiet gate: adc level below threshold plus amp and boost gain
    assign gate_lhs_w = GATE_BASE_Q
                        + 11'(gate_reg[2:0]) * GATE_STEP_Q;
    assign gate_rhs_w = {1'b0, sync2_reg[13:6], 2'b00}
                        + 11'(gain_reg) * 11'h003
                        + {3'b000, sync2_reg[5:0], 2'b00};
    assign gate_w = enable_reg && !mode_reg
                    && gate_reg[GATE_EN_BIT]
                    && gate_lhs_w < gate_rhs_w;

    // interval selection
    assign atk_base_w = mode_reg ? ATK_LIM_CYC : ATK_NORM_CYC;
    assign dcy_base_w = mode_reg ? DCY_LIM_CYC : DCY_NORM_CYC;
    assign hold_len_w = scaled(HOLD_CYC, hold_code_reg - 4'h1);

    always_comb begin
        case (state_reg)
            ST_ATTACK: cur_int_w = peak_s ? ATK_LIM_CYC
                : scaled(atk_base_w, rates_reg[3:0]);
            ST_DECAY: cur_int_w =
                scaled(dcy_base_w, rates_reg[DCY_LSB+:4]);
            ST_HOLD: cur_int_w = hold_len_w;
            default: cur_int_w = 32'h0000_0001;
        endcase
    end

    assign step_w = (state_reg == ST_ATTACK || state_reg == ST_DECAY)
                    && cnt_reg >= cur_int_w - 32'h1;

    assign decay_or_hold_w = (!mode_reg && hold_code_reg != 4'h0)
                             ? ST_HOLD : ST_DECAY;

    always_comb begin
        case (state_reg)
            ST_OFF: state_next = enable_reg
                ? (over_s ? ST_ATTACK : decay_or_hold_w) : ST_OFF;
            ST_ATTACK: state_next = !enable_reg ? ST_OFF
                : (over_s ? ST_ATTACK : decay_or_hold_w);
            ST_HOLD: begin
                if (!enable_reg)
                    state_next = ST_OFF;
                else if (over_s || mode_reg)
                    state_next = ST_ATTACK;
                else if (cnt_reg >= hold_len_w - 32'h1)
                    state_next = ST_DECAY;
                else
                    state_next = ST_HOLD;
            end
            ST_DECAY: state_next = !enable_reg ? ST_OFF
                : (over_s ? ST_ATTACK : ST_DECAY);
            default: state_next = ST_OFF;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            state_reg <= ST_OFF;
        else
            state_reg <= state_next;
    end

    // gated decay keeps the counter at zero, so release waits a full step
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            cnt_reg <= '0;
        else if (state_next != state_reg || state_reg == ST_OFF)
            cnt_reg <= '0;
        else if (step_w || (state_reg == ST_DECAY && gate_w))
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + 32'h1;
    end

    // starting gain for limiter: at enable or on switch from normal
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            enable_prev_reg <= 1'b0;
            mode_prev_reg <= 1'b0;
            start_reg <= GAIN_RST;
        end else begin
            enable_prev_reg <= enable_reg;
            mode_prev_reg <= mode_reg;
            if (start_cap_w)
                start_reg <= gain_reg;
        end
    end

    // a volume write always lands; with the loop enabled it is re-clamped next cycle, while disabled it is kept
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            gain_reg <= GAIN_RST;
        else if (wr_vol_w)
            gain_reg <= i_pwdata[GAIN_W-1:0];
        else if (!enable_reg)
            gain_reg <= gain_reg;
        else if (gain_reg > upper_w)
            gain_reg <= upper_w;
        else if (gain_reg < lower_w)
            gain_reg <= lower_w;
        else if (step_w && state_reg == ST_ATTACK && gain_reg > lower_w)
            gain_reg <= gain_reg - 6'h01;
        else if (step_w && state_reg == ST_DECAY && !gate_w
                 && gain_reg < upper_w)
            gain_reg <= gain_reg + 6'h01;
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_pga_gain = gain_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    sequence in_range_s;
        enable_reg && !wr_vol_w && gain_reg >= lower_w
            && gain_reg <= upper_w;
    endsequence

    sequence hold_done_s;
        state_reg == ST_HOLD && enable_reg && !over_s && !mode_reg
            && cnt_reg >= hold_len_w - 32'h1;
    endsequence

    ceiling_clamp_a:
    assert property (enable_reg && !wr_vol_w && gain_reg > upper_w
                     |=> gain_reg == $past(upper_w))
        else $error("gain above ceiling not pulled back");

    floor_clamp_a:
    assert property (enable_reg && !wr_vol_w && gain_reg <= upper_w
                     && gain_reg < lower_w |=> gain_reg == $past(lower_w))
        else $error("gain below floor not pulled back");

    disabled_hold_a:
    assert property (!enable_reg && !wr_vol_w |=> $stable(gain_reg))
        else $error("gain moved while loop disabled");

    limiter_bound_a:
    assert property (enable_reg && mode_reg && $stable(enable_reg)
                     && gain_reg <= start_reg && !wr_vol_w
                     |=> gain_reg <= start_reg)
        else $error("limiter raised gain past start");

    attack_step_a:
    assert property (in_range_s ##0 (step_w && state_reg == ST_ATTACK
                     && gain_reg > lower_w)
                     |=> gain_reg == $past(gain_reg) - 6'h01)
        else $error("attack step did not lower gain by one");

    peak_rate_a:
    assert property (in_range_s ##0 (state_reg == ST_ATTACK && peak_s
                     && cnt_reg >= ATK_LIM_CYC - 32'h1
                     && gain_reg > lower_w)
                     |=> gain_reg == $past(gain_reg) - 6'h01)
        else $error("peak limiter not at fastest attack");

    gate_freeze_a:
    assert property (in_range_s ##0 (state_reg == ST_DECAY && gate_w)
                     |=> $stable(gain_reg))
        else $error("gain rose while noise gate active");

    hold_abandon_a:
    assert property (state_reg == ST_HOLD && enable_reg && over_s
                     |=> state_reg == ST_ATTACK)
        else $error("hold not abandoned above threshold");

    hold_expiry_a:
    assert property (hold_done_s |=> state_reg == ST_DECAY)
        else $error("decay did not start after hold");

    limiter_no_hold_a:
    assert property (enable_reg && mode_reg && state_reg != ST_HOLD
                     |=> state_reg != ST_HOLD)
        else $error("hold entered in limiter mode");

    peak_off_a:
    assert property (!enable_reg |-> !peak_s ##1 state_reg == ST_OFF)
        else $error("limiter active with loop disabled");

endmodule // alc_gain_loop

/* File: include/alc_pkg.sv */
// constants for the automatic level control gain loop
package alc_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 10;

    // step interval bases, printed times in microseconds
    localparam real ATK_LIM_BASE_US = 22.7;
    localparam real DCY_LIM_BASE_US = 90.8;
    localparam real ATK_NORM_BASE_US = 104.0;
    localparam real DCY_NORM_BASE_US = 410.0;
    localparam real HOLD_BASE_US = 2670.0;
    localparam int ATK_LIM_BASE_CYC =
        int'(ATK_LIM_BASE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int DCY_LIM_BASE_CYC =
        int'(DCY_LIM_BASE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int ATK_NORM_BASE_CYC =
        int'(ATK_NORM_BASE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int DCY_NORM_BASE_CYC =
        int'(DCY_NORM_BASE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int HOLD_BASE_CYC =
        int'(HOLD_BASE_US * 1000.0 / CLK_PERIOD_NS);
    localparam logic [3:0] RATE_CODE_MAX = 4'hA;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_GAIN_LIMITS = 10'h020;
    localparam logic [9:0] IDX_HOLD_DELAY = 10'h021;
    localparam logic [9:0] IDX_RATES = 10'h022;
    localparam logic [9:0] IDX_QUIET_GATE = 10'h023;
    localparam logic [9:0] IDX_LOOP_CTRL = 10'h024;
    localparam logic [9:0] IDX_AMP_VOLUME = 10'h025;
    localparam logic [9:0] IDX_LOOP_STATUS = 10'h026;

    // field positions and reset values
    localparam int CEIL_LSB = 3;
    localparam int HOLD_LSB = 4;
    localparam int DCY_LSB = 4;
    localparam int GATE_EN_BIT = 3;
    localparam int CTRL_MODE_BIT = 1;
    localparam logic [5:0] LIMITS_RST = 6'h38;
    localparam logic [3:0] HOLD_RST = 4'h0;
    localparam logic [7:0] RATES_RST = 8'h00;
    localparam logic [3:0] GATE_RST = 4'h0;
    localparam logic [5:0] GAIN_RST = 6'h10;

    // noise gate compare in quarter-dB units
    localparam logic [10:0] GATE_BASE_Q = 11'h0CC;
    localparam logic [10:0] GATE_STEP_Q = 11'h018;

    localparam int GAIN_W = 6;
    localparam int SYNC_W = 16;

    typedef enum logic [1:0] {ST_OFF, ST_ATTACK, ST_HOLD, ST_DECAY} state_t;
endpackage

/* File: verification/alc_front_model.sv */
// stand-in for the input amplifier and the adc level detector
`timescale 1ns/100ps
module alc_front_model #(
    parameter logic [5:0] BOOST_DB = 6'h00
) (
    input wire logic [1:0] i_level,
    output logic o_above_threshold,
    output logic o_above_peak,
    output logic [7:0] o_adc_atten_db,
    output logic [5:0] o_boost_db
);
    // level 0 noise, 1 quiet tone, 2 loud, 3 near clipping
    assign o_above_threshold = i_level[1];
    assign o_above_peak = (i_level == 2'h3);
    // noise sits far down so the gate sees it; tones sit at full scale
    assign o_adc_atten_db = (i_level == 2'h0) ? 8'h78 : 8'h00;
    assign o_boost_db = BOOST_DB;
endmodule // alc_front_model

/* File: verification/alc_gain_limits_hold_noise_gate_test.sv */
// self-checking bench for the gain loop controller
`timescale 1ns/100ps
`define CHK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        fail_count++; \
        $display("BAD %0t %h %h", $time, (a), (b)); \
    end \
end
module alc_gain_limits_hold_noise_gate_test import alc_pkg::*;;
    localparam int ATK = 4;
    localparam int DCY = 8;
    localparam int NDCY = 10;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] level = 2'h0;
    logic thr;
    logic peak;
    logic [7:0] atten;
    logic [5:0] boost;
    logic [5:0] gain;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    alc_gain_loop #(.ATK_LIM_CYC(4), .DCY_LIM_CYC(8), .ATK_NORM_CYC(5),
        .DCY_NORM_CYC(10), .HOLD_CYC(20)) DUT (
        .i_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_above_threshold(thr),
        .i_above_peak(peak), .i_adc_atten_db(atten),
        .i_boost_db(boost), .o_pga_gain(gain)
    );

    alc_front_model front (
        .i_level(level), .o_above_threshold(thr), .o_above_peak(peak),
        .o_adc_atten_db(atten), .o_boost_db(boost)
    );

    task conclude;
        if (fail_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // values read before the edge's updates land: what the edge samples
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never completes
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        `CHK(rd, exp)
    endtask

    // cycles between two successive gain steps, and the step itself
    task gap(input int exp, input logic [5:0] dlt);
        logic [5:0] g;
        int n;
        for (int i = 0; i < 2; i++) begin
            g = gain;
            n = 0;
            while (gain === g && n < 9000) begin
                @(posedge clk);
                n++;
            end
        end
        `CHK(n, exp)
        `CHK(6'(gain - g), dlt)
    endtask

    task t_regs;
        rchk(IDX_GAIN_LIMITS, 32'h38);
        rchk(IDX_HOLD_DELAY, 32'h0);
        rchk(IDX_QUIET_GATE, 32'h0);
        apb(1'b0, 10'h027, 32'h0);
        `CHK({er, rd}, 33'h100000000)
        apb(1'b1, IDX_QUIET_GATE, 32'h1F);
        rchk(IDX_QUIET_GATE, 32'hF);
    endtask

    task t_off;
        apb(1'b1, IDX_GAIN_LIMITS, 32'h0);
        repeat (20) @(posedge clk);
        `CHK(gain, 6'h10)
        apb(1'b1, IDX_AMP_VOLUME, 32'h30);
        rchk(IDX_AMP_VOLUME, 32'h30);
    endtask

    task t_clamp;
        apb(1'b1, IDX_QUIET_GATE, 32'h8);
        apb(1'b1, IDX_GAIN_LIMITS, 32'h18);
        apb(1'b1, IDX_LOOP_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        `CHK(gain, 6'h1F)
        apb(1'b1, IDX_GAIN_LIMITS, 32'h35);
        repeat (30) @(posedge clk);
        `CHK(gain, 6'h28)
        apb(1'b1, IDX_QUIET_GATE, 32'h0);
        gap(NDCY, 6'h01);
        repeat (200) @(posedge clk);
        `CHK(gain, 6'h37)
    endtask

    task t_hold;
        logic [5:0] g;
        apb(1'b1, IDX_HOLD_DELAY, 32'h20);
        level <= 2'h2;
        repeat (20) @(posedge clk);
        level <= 2'h1;
        repeat (5) @(posedge clk);
        g = gain;
        repeat (30) @(posedge clk);
        `CHK(gain, g)
        level <= 2'h2;
        repeat (15) @(posedge clk);
        `CHK(gain < g, 1'b1)
        level <= 2'h1;
        repeat (5) @(posedge clk);
        g = gain;
        repeat (70) @(posedge clk);
        `CHK(gain > g, 1'b1)
        // slowest normal attack, so only the peak path can be this fast
        apb(1'b1, IDX_RATES, 32'h0A);
        level <= 2'h3;
        gap(ATK, 6'h3F);
    endtask

    task t_lim;
        apb(1'b1, IDX_LOOP_CTRL, 32'h0);
        apb(1'b1, IDX_GAIN_LIMITS, 32'h38);
        apb(1'b1, IDX_AMP_VOLUME, 32'h20);
        apb(1'b1, IDX_LOOP_CTRL, 32'h3);
        level <= 2'h2;
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, IDX_RATES, 32'(k));
            gap(ATK << k, 6'h3F);
        end
        apb(1'b1, IDX_QUIET_GATE, 32'h8);
        level <= 2'h0;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, IDX_RATES, 32'(k << 4));
            gap(DCY << k, 6'h01);
        end
        repeat (150) @(posedge clk);
        `CHK(gain, 6'h20)
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_off();
        t_clamp();
        t_hold();
        t_lim();
        conclude();
    end
endmodule // alc_gain_limits_hold_noise_gate_test
